// File: inc/slb_map.svh
// Purpose: offsets, field positions, reset values and counts of the control bridge
// Assumes: 100 MHz core clock
// Notes: offsets are positions in the bridge's own I2C register space
`ifndef SLB_MAP_SVH
`define SLB_MAP_SVH
`define SLB_OFS_ADDR 8'h00
`define SLB_OFS_CTRL 8'h01
`define SLB_OFS_GPIO 8'h02
`define SLB_OFS_STAT 8'h03
`define SLB_OFS_ALIAS 8'h08
`define SLB_OFS_REAL 8'h10
`define SLB_RST_ADDR 8'hb0
`define SLB_BIT_SEL 0
`define SLB_BIT_PASS 0
`define SLB_BIT_DISP 1
`define SLB_STRAP_BASE 7'h58
`define SLB_STRAP_MAX 3'h5
`define SLB_STRAP_WAIT 2'h3
`define SLB_NUM_ALIAS 8
`define SLB_GPIO_W 4
`define SLB_BUS_RATE_KBPS 400
`define SLB_CLK_MHZ 100
`define SLB_BIT_CYC ((`SLB_CLK_MHZ * 1000) / `SLB_BUS_RATE_KBPS)
`endif

// File: inc/slb_pkg.sv
// Purpose: types of the control bridge
// Assumes: slb_map.svh holds all numbers
// Notes: whole bridge state is one packed struct
`include "slb_map.svh"
package slb_pkg;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_ADDR = 4'h1,
		S_ACK = 4'h2,
		S_RX = 4'h3,
		S_TX = 4'h4,
		S_RACK = 4'h5,
		S_LWAIT = 4'h6,
		S_LSTOP = 4'h7
	} slb_state_e;

	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ = 2'h2,
		OP_STOP = 2'h3
	} slb_op_e;

	typedef logic [`SLB_NUM_ALIAS-1:0][6:0] slb_tab_t;

	typedef struct packed {
		slb_state_e state;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic rw;
		logic nak;
		logic [7:0] ptr;
		logic got_ptr;
		logic fwd;
		logic scl_oe;
		logic sda_oe;
		logic link_req;
		slb_op_e link_op;
		logic [7:0] link_byte;
		logic [7:0] addr_reg;
		logic [1:0] ctrl;
		logic [`SLB_GPIO_W-1:0] gpio;
		slb_tab_t alias_tab;
		slb_tab_t real_tab;
		logic [6:0] strap_addr;
		logic [1:0] strap_cnt;
	} slb_st_s;
endpackage

// File: rtl/slb_ctrl_bridge.sv
// Purpose: I2C target port with register file, pass-through and alias bridging over the link
// Assumes: link partner answers each request with one I_LINK_DONE pulse
// Notes: SCL and SDA are open drain, driven only low
// Operation
// - Own I2C target sets up feature registers and drives the general purpose outputs.
// - Lines are driven low only; high comes from the external pull-up.
// - Port runs at fast-mode rates up to 400 kbps.
// - With pass-through on, transactions for remote devices are carried over the link.
// - With pass-through off, transactions for remote targets are not forwarded.
// - During bridged transfers SCL is held low before the ninth clock of written bytes and before the first bit of read bytes until remote answers.
// - Target never makes clocks; it only stretches the SCL low phase.
// - One strap input is decoded into one of six own addresses.
// - Strap codes 0 to 5 give addresses 0x58 to 0x5D.
// - Sensor mode supports eight alias addresses remapped to real target addresses.
// - Display mode supports one alias address only.
// - Alias address is recognised and the real address is issued remotely.
// - Remote side masters its bus while this port acts as a target.
// - Address register select bit picks strap or programmed own address.
`timescale 1ns/1ps
`include "slb_map.svh"
module slb_ctrl_bridge
	import slb_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_NRST,
	input wire logic I_SCL_IN,
	input wire logic I_SDA_IN,
	output logic O_SCL_OUT,
	output logic O_SCL_OE,
	output logic O_SDA_OUT,
	output logic O_SDA_OE,
	input wire logic [2:0] I_ADDRESS_STRAP_INPUT,
	output logic [`SLB_GPIO_W-1:0] O_GPIO,
	output logic O_LINK_REQ,
	output logic [1:0] O_LINK_OP,
	output logic [7:0] O_LINK_BYTE,
	input wire logic I_LINK_DONE,
	input wire logic I_LINK_ACK,
	input wire logic [7:0] I_LINK_RDATA
);
	slb_st_s r;
	slb_st_s n;
	logic scl_rise;
	logic scl_fall;
	logic sda_lvl;
	logic ev_start;
	logic ev_stop;
	logic [2:0] strap_s;
	logic [2:0] strap_code;
	logic [6:0] own_addr;
	logic [`SLB_NUM_ALIAS-1:0] hit;
	logic [6:0] real_addr;
	logic any_hit;

	// Two-stage sampling gives 250 core cycles per 400 kbps bit, ample margin
	slb_pin_sync u_sync (
		.i_clk(I_CORE_CLK),
		.i_nrst(I_NRST),
		.i_scl(I_SCL_IN),
		.i_sda(I_SDA_IN),
		.i_strap(I_ADDRESS_STRAP_INPUT),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_sda(sda_lvl),
		.o_start(ev_start),
		.o_stop(ev_stop),
		.o_strap(strap_s)
	);

	// Codes above five are out of range; clamp to the last address
	assign strap_code = (strap_s > `SLB_STRAP_MAX) ? `SLB_STRAP_MAX : strap_s;
	assign own_addr = r.addr_reg[`SLB_BIT_SEL] ? r.addr_reg[7:1] : r.strap_addr;

	genvar gi;
	generate
		for (gi = 0; gi < `SLB_NUM_ALIAS; gi++) begin : g_alias
			// Display mode leaves only the first entry live
			assign hit[gi] = (r.alias_tab[gi] == r.shreg[7:1]) && ((gi == 0) || !r.ctrl[`SLB_BIT_DISP]);
		end
	endgenerate

	always_comb begin
		real_addr = r.shreg[7:1];
		any_hit = 1'b0;
		for (int k = `SLB_NUM_ALIAS - 1; k >= 0; k--) begin
			if (hit[k]) begin
				real_addr = r.real_tab[k];
				any_hit = 1'b1;
			end
		end
	end

	function automatic logic [7:0] rd_reg(input slb_st_s s, input logic [7:0] a);
		rd_reg = 8'h00;
		if (a == `SLB_OFS_ADDR) begin
			rd_reg = s.addr_reg;
		end else if (a == `SLB_OFS_CTRL) begin
			rd_reg = {6'h00, s.ctrl};
		end else if (a == `SLB_OFS_GPIO) begin
			rd_reg = {{(8 - `SLB_GPIO_W){1'b0}}, s.gpio};
		end else if (a == `SLB_OFS_STAT) begin
			rd_reg = {s.fwd, s.strap_addr};
		end else if (a[7:3] == `SLB_OFS_ALIAS / 8) begin
			rd_reg = {s.alias_tab[a[2:0]], 1'b0};
		end else if (a[7:3] == `SLB_OFS_REAL / 8) begin
			rd_reg = {s.real_tab[a[2:0]], 1'b0};
		end
	endfunction

	always_comb begin
		n = r;
		// Strap is caught only once the synchroniser holds real pin values
		if (r.strap_cnt != `SLB_STRAP_WAIT) begin
			n.strap_cnt = r.strap_cnt + 2'h1;
			n.strap_addr = `SLB_STRAP_BASE + {4'h0, strap_code};
		end
		unique case (r.state)
			S_IDLE: begin
			end
			S_ADDR: begin
				if (scl_rise) begin
					n.shreg = {r.shreg[6:0], sda_lvl};
					n.cnt = r.cnt + 4'h1;
				end else if (scl_fall && r.cnt == 4'h8) begin
					n.rw = r.shreg[0];
					n.cnt = 4'h0;
					if (r.shreg[7:1] == own_addr) begin
						n.fwd = 1'b0;
						n.nak = 1'b0;
						n.sda_oe = 1'b1;
						n.state = S_ACK;
					end else if (r.ctrl[`SLB_BIT_PASS]) begin
						n.fwd = 1'b1;
						n.scl_oe = 1'b1;
						n.link_req = 1'b1;
						n.link_op = OP_START;
						n.link_byte = {any_hit ? real_addr : r.shreg[7:1], r.shreg[0]};
						n.state = S_LWAIT;
					end else begin
						n.state = S_IDLE;
					end
				end
			end
			S_ACK: begin
				if (scl_fall) begin
					n.sda_oe = 1'b0;
					n.cnt = 4'h0;
					if (r.nak) begin
						n.state = S_IDLE;
					end else if (!r.rw) begin
						n.state = S_RX;
					end else if (r.fwd) begin
						n.scl_oe = 1'b1;
						n.link_req = 1'b1;
						n.link_op = OP_READ;
						n.state = S_LWAIT;
					end else begin
						n.shreg = rd_reg(r, r.ptr);
						n.ptr = r.ptr + 8'h01;
						n.sda_oe = ~n.shreg[7];
						n.state = S_TX;
					end
				end
			end
			S_RX: begin
				if (scl_rise) begin
					n.shreg = {r.shreg[6:0], sda_lvl};
					n.cnt = r.cnt + 4'h1;
				end else if (scl_fall && r.cnt == 4'h8) begin
					n.cnt = 4'h0;
					if (r.fwd) begin
						n.scl_oe = 1'b1;
						n.link_req = 1'b1;
						n.link_op = OP_WRITE;
						n.link_byte = r.shreg;
						n.state = S_LWAIT;
					end else begin
						n.nak = 1'b0;
						n.sda_oe = 1'b1;
						n.state = S_ACK;
						if (!r.got_ptr) begin
							n.ptr = r.shreg;
							n.got_ptr = 1'b1;
						end else begin
							n.ptr = r.ptr + 8'h01;
							if (r.ptr == `SLB_OFS_ADDR) begin
								n.addr_reg = r.shreg;
							end else if (r.ptr == `SLB_OFS_CTRL) begin
								n.ctrl = r.shreg[1:0];
							end else if (r.ptr == `SLB_OFS_GPIO) begin
								n.gpio = r.shreg[`SLB_GPIO_W-1:0];
							end else if (r.ptr[7:3] == `SLB_OFS_ALIAS / 8) begin
								n.alias_tab[r.ptr[2:0]] = r.shreg[7:1];
							end else if (r.ptr[7:3] == `SLB_OFS_REAL / 8) begin
								n.real_tab[r.ptr[2:0]] = r.shreg[7:1];
							end
						end
					end
				end
			end
			S_TX: begin
				if (scl_fall) begin
					if (r.cnt == 4'h7) begin
						n.sda_oe = 1'b0;
						n.state = S_RACK;
					end else begin
						n.shreg = {r.shreg[6:0], 1'b0};
						n.sda_oe = ~r.shreg[6];
						n.cnt = r.cnt + 4'h1;
					end
				end
			end
			S_RACK: begin
				if (scl_rise) begin
					n.nak = sda_lvl;
				end else if (scl_fall) begin
					n.cnt = 4'h0;
					if (r.nak) begin
						n.state = S_IDLE;
					end else if (r.fwd) begin
						n.scl_oe = 1'b1;
						n.link_req = 1'b1;
						n.link_op = OP_READ;
						n.state = S_LWAIT;
					end else begin
						n.shreg = rd_reg(r, r.ptr);
						n.ptr = r.ptr + 8'h01;
						n.sda_oe = ~n.shreg[7];
						n.state = S_TX;
					end
				end
			end
			S_LWAIT: begin
				if (I_LINK_DONE) begin
					n.link_req = 1'b0;
					n.scl_oe = 1'b0;
					if (r.link_op == OP_READ) begin
						n.shreg = I_LINK_RDATA;
						n.sda_oe = ~I_LINK_RDATA[7];
						n.cnt = 4'h0;
						n.state = S_TX;
					end else begin
						n.nak = ~I_LINK_ACK;
						n.sda_oe = I_LINK_ACK;
						n.state = S_ACK;
					end
				end
			end
			S_LSTOP: begin
				if (I_LINK_DONE) begin
					n.link_req = 1'b0;
					n.fwd = 1'b0;
					n.state = S_IDLE;
				end
			end
		endcase
		// SCL is held low in S_LWAIT only; start and stop are ignored in both S_LWAIT and S_LSTOP
		if (r.state != S_LWAIT && r.state != S_LSTOP) begin
			if (ev_start) begin
				n.state = S_ADDR;
				n.cnt = 4'h0;
				n.got_ptr = 1'b0;
				n.sda_oe = 1'b0;
				n.scl_oe = 1'b0;
			end else if (ev_stop) begin
				n.sda_oe = 1'b0;
				n.scl_oe = 1'b0;
				n.got_ptr = 1'b0;
				if (r.fwd) begin
					n.link_req = 1'b1;
					n.link_op = OP_STOP;
					n.state = S_LSTOP;
				end else begin
					n.state = S_IDLE;
				end
			end
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_NRST) begin
			r <= '0;
			r.addr_reg <= `SLB_RST_ADDR;
		end else begin
			r <= n;
		end
	end

	assign O_SCL_OUT = 1'b0;
	assign O_SDA_OUT = 1'b0;
	assign O_SCL_OE = r.scl_oe;
	assign O_SDA_OE = r.sda_oe;
	assign O_GPIO = r.gpio;
	assign O_LINK_REQ = r.link_req;
	assign O_LINK_OP = r.link_op;
	assign O_LINK_BYTE = r.link_byte;
endmodule

// File: rtl/slb_pin_sync.sv
// Purpose: pin synchroniser and bus event detector
// Assumes: pins are asynchronous to the core clock
// Notes: events come from the second stage only
`timescale 1ns/1ps
module slb_pin_sync
	import slb_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic [2:0] i_strap,
	output logic o_scl_rise,
	output logic o_scl_fall,
	output logic o_sda,
	output logic o_start,
	output logic o_stop,
	output logic [2:0] o_strap
);
	logic [4:0] s1_r;
	logic [4:0] s2_r;
	logic [1:0] prev_r;

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			// Idle bus reads high, so no false start after reset
			s1_r <= 5'h03;
			s2_r <= 5'h03;
			prev_r <= 2'h3;
		end else begin
			s1_r <= {i_strap, i_sda, i_scl};
			s2_r <= s1_r;
			prev_r <= s2_r[1:0];
		end
	end

	assign o_scl_rise = s2_r[0] & ~prev_r[0];
	assign o_scl_fall = ~s2_r[0] & prev_r[0];
	assign o_sda = s2_r[1];
	assign o_start = s2_r[0] & prev_r[0] & prev_r[1] & ~s2_r[1];
	assign o_stop = s2_r[0] & prev_r[0] & ~prev_r[1] & s2_r[1];
	assign o_strap = s2_r[4:2];
endmodule

// File: verification/slb_ctrl_bridge_props.sv
// Purpose: port checks of the bridge
// Assumes: wires are AND of pull-downs
// Notes: bound to the top module
`timescale 1ns/1ps
`include "slb_map.svh"
module slb_ctrl_bridge_props (
	input logic I_CORE_CLK,
	input logic I_NRST,
	input logic I_SCL_IN,
	input logic O_SCL_OUT,
	input logic O_SCL_OE,
	input logic O_SDA_OUT,
	input logic O_SDA_OE,
	input logic [`SLB_GPIO_W-1:0] O_GPIO,
	input logic O_LINK_REQ,
	input logic [1:0] O_LINK_OP,
	input logic [7:0] O_LINK_BYTE,
	input logic I_LINK_DONE
);
	default clocking @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_NRST);
	out_low_a: assert property (!O_SCL_OUT && !O_SDA_OUT)
		else $error("drive level high");
	stretch_req_a: assert property ($rose(O_LINK_REQ) && O_LINK_OP != 2'h3 |-> O_SCL_OE)
		else $error("no stretch");
	stretch_end_a: assert property (O_LINK_REQ && I_LINK_DONE |=> !O_LINK_REQ && !O_SCL_OE)
		else $error("stretch kept");
	stretch_only_a: assert property (O_SCL_OE |-> O_LINK_REQ)
		else $error("clock held idle");
	req_hold_a: assert property (O_LINK_REQ && !I_LINK_DONE |=>
		O_LINK_REQ && $stable(O_LINK_BYTE) && $stable(O_LINK_OP))
		else $error("request moved");
	req_end_a: assert property ($fell(O_LINK_REQ) |-> $past(I_LINK_DONE))
		else $error("request unanswered");
	sda_change_a: assert property ($changed(O_SDA_OE) |-> !$past(I_SCL_IN))
		else $error("data moved in high");
	reset_quiet_a: assert property (disable iff (1'b0) !I_NRST |=> !O_SDA_OE && !O_LINK_REQ && O_GPIO == '0)
		else $error("active in reset");
	cover property ($rose(O_LINK_REQ) && O_LINK_OP == 2'h2);
	cover property (O_SCL_OE && I_LINK_DONE);
	cover property ($changed(O_GPIO));
endmodule
bind slb_ctrl_bridge slb_ctrl_bridge_props i_props (.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST),
	.I_SCL_IN(I_SCL_IN), .O_SCL_OUT(O_SCL_OUT), .O_SCL_OE(O_SCL_OE), .O_SDA_OUT(O_SDA_OUT),
	.O_SDA_OE(O_SDA_OE), .O_GPIO(O_GPIO), .O_LINK_REQ(O_LINK_REQ), .O_LINK_OP(O_LINK_OP),
	.O_LINK_BYTE(O_LINK_BYTE), .I_LINK_DONE(I_LINK_DONE));

// File: verification/slb_ctrl_bridge_tb.sv
// Purpose: bench of the bridge
// Assumes: 400 kbps master
// Notes: wires are AND of drivers
`timescale 1ns/1ps
module slb_ctrl_bridge_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ms = 1'b1;
	logic md = 1'b1;
	logic [2:0] strap = 3'h0;
	logic [6:0] own = 7'h5d;
	logic so, dd, req, dn, ak, a;
	logic [1:0] op;
	logic [7:0] lb, rd, d;
	logic [3:0] gp;
	int err_total = 0;
	int n_tests = 0;
	wire scl = ms & ~so;
	wire sda = md & ~dd;
	always #5 clk = ~clk;
	slb_ctrl_bridge i_dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_SCL_IN(scl), .I_SDA_IN(sda),
		.O_SCL_OUT(), .O_SCL_OE(so), .O_SDA_OUT(), .O_SDA_OE(dd), .I_ADDRESS_STRAP_INPUT(strap),
		.O_GPIO(gp), .O_LINK_REQ(req), .O_LINK_OP(op), .O_LINK_BYTE(lb), .I_LINK_DONE(dn),
		.I_LINK_ACK(ak), .I_LINK_RDATA(rd));
	slb_link_model i_link (.i_clk(clk), .i_req(req), .i_op(op), .i_byte(lb), .o_done(dn),
		.o_ack(ak), .o_rdata(rd));
	task pin(input logic s, input logic v);
		ms = s;
		md = v;
		repeat (63) @(posedge clk);
		#1;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task bt(input logic b, output logic r);
		pin(1'b0, b);
		ms = 1'b1;
		for (int k = 0; k < 9000 && scl !== 1'b1; k++) @(posedge clk);
		#1;
		if (scl !== 1'b1) chk({7'h0, scl}, 8'h01);
		pin(1'b1, b);
		r = sda;
		pin(1'b1, b);
		pin(1'b0, b);
	endtask
	task wb(input logic [7:0] v, output logic k);
		logic r;
		for (int i = 7; i >= 0; i--) bt(v[i], r);
		bt(1'b1, r);
		k = ~r;
	endtask
	task rb();
		logic r;
		for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
		bt(1'b1, r);
	endtask
	task st(input logic [7:0] v);
		pin(ms, 1'b1);
		pin(1'b1, 1'b1);
		pin(1'b1, 1'b0);
		pin(1'b0, 1'b0);
		wb(v, a);
	endtask
	task sp();
		pin(1'b0, 1'b0);
		pin(1'b1, 1'b0);
		pin(1'b1, 1'b1);
	endtask
	task wreg(input logic [7:0] o, input logic [15:0] v, input int n);
		logic k0, k1, k2, k3;
		k3 = 1'b1;
		st({own, 1'b0});
		k0 = a;
		wb(o, k1);
		wb(v[15:8], k2);
		if (n > 1) wb(v[7:0], k3);
		sp();
		chk({4'h0, k0, k1, k2, k3}, 8'h0f);
	endtask
	task t_strap();
		for (int s = 0; s < 6; s++) begin
			strap = s[2:0];
			nrst = 1'b0;
			repeat (20) @(posedge clk);
			#1;
			nrst = 1'b1;
			repeat (6) @(posedge clk);
			#1;
			st({7'h58 + s[6:0], 1'b0});
			sp();
			chk({7'h0, a}, 8'h01);
		end
		st(8'hb8);
		sp();
		chk({7'h0, a}, 8'h00);
		chk(i_link.n_req[7:0], 8'h00);
		$display("strap test done");
	endtask
	task t_local();
		wreg(8'h02, 16'h0a00, 1);
		chk({4'h0, gp}, 8'h0a);
		st(8'hba);
		wb(8'h03, a);
		st(8'hbb);
		rb();
		sp();
		chk(d, 8'h5d);
		wreg(8'h00, 16'h6701, 2);
		st(8'h66);
		sp();
		chk({7'h0, a}, 8'h01);
		chk(i_link.n_req[7:0], 8'h00);
		own = 7'h33;
		$display("local test done");
	endtask
	task t_bridge();
		wreg(8'h08, 16'ha4a6, 2);
		wreg(8'h10, 16'ha0a2, 2);
		st(8'ha4);
		wb(8'h3c, a);
		sp();
		chk(i_link.start_b, 8'ha0);
		chk({7'h0, a}, 8'h01);
		chk(i_link.wr_b, 8'h3c);
		st(8'h89);
		rb();
		sp();
		chk(d, 8'h96);
		chk(i_link.start_b, 8'h89);
		st(8'ha6);
		sp();
		chk(i_link.start_b, 8'ha2);
		chk(i_link.n_req[7:0], 8'h08);
		wreg(8'h01, 16'h0300, 1);
		st(8'ha6);
		sp();
		chk(i_link.start_b, 8'ha6);
		chk({7'h0, a}, 8'h00);
		chk(i_link.n_req[7:0], 8'h0a);
		nrst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		nrst = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk({4'h0, gp}, 8'h00);
		$display("bridge test done");
	endtask
	task give_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		t_strap();
		t_local();
		t_bridge();
		give_verdict();
	end
	initial begin
		repeat (97000) @(posedge clk);
		err_total++;
		give_verdict();
	end
endmodule

// File: verification/slb_link_model.sv
// Purpose: far end of the link
// Assumes: one done pulse per request
// Notes: answers fast and slow in turn
`timescale 1ns/1ps
module slb_link_model #(
	parameter logic [7:0] RD = 8'h96,
	parameter logic [7:0] NAK_B = 8'ha6
) (
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic [1:0] i_op,
	input wire logic [7:0] i_byte,
	output logic o_done = 1'b0,
	output logic o_ack = 1'b0,
	output logic [7:0] o_rdata = 8'h00
);
	logic [7:0] start_b = 8'h00;
	logic [7:0] wr_b = 8'h00;
	logic req_q = 1'b0;
	logic slow = 1'b0;
	int n_req = 0;
	int cnt = 0;
	// Junk on answer lines outside done
	always @(posedge i_clk) begin
		req_q <= i_req;
		o_done <= 1'b0;
		o_ack <= ~o_ack;
		o_rdata <= ~o_rdata;
		if (i_req && !req_q) begin
			cnt <= slow ? 40 : 1;
			slow <= ~slow;
			n_req <= n_req + 1;
			if (i_op == 2'h0) start_b <= i_byte;
			if (i_op == 2'h1) wr_b <= i_byte;
		end else if (cnt == 1) begin
			o_done <= 1'b1;
			// One remote address is absent and refuses its start
			o_ack <= (i_op != 2'h0) || (i_byte != NAK_B);
			o_rdata <= RD;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule
